// ===== dv/sisa_agent_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench: host model on the line, random request levels
module sisa_agent_tb;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [15:1] irq_data = '1;
	logic        smi_n = 1'b1;
	logic        smi_en = 1'b0;
	logic        go = 1'b0;
	logic [2:0]  start_len = 3'h3;
	logic [2:0]  stop_len = 3'h3;
	logic        dev_out;
	logic        dev_oe_n;
	logic        quiet_mode;
	logic        cycle_active;
	logic        h_out;
	logic        h_oe_n;
	logic        done;
	logic        line;
	logic [16:1] seen;
	logic [16:1] exp_v;
	logic [16:1] last_v = '1;
	logic        own;
	logic [31:0] r;
	int          bad_count = 0;
	int          n_checks = 0;
	int          seed = 61022;
	int          k;
	int          i;

	// ==========================================================================
	// Clock and shared line; pull-up wins when nobody drives
	always #10 mclk = ~mclk;
	assign line = !dev_oe_n ? dev_out : (!h_oe_n ? h_out : 1'b1);

	sisa_agent DUT (
		.mclk                       (mclk),
		.reset_n                    (reset_n),
		.irq_data                   (irq_data),
		.system_mgmt_interrupt_n    (smi_n),
		.smi_slot_en                (smi_en),
		.serial_interrupt_line_in   (line),
		.serial_interrupt_line_out  (dev_out),
		.serial_interrupt_line_oe_n (dev_oe_n),
		.quiet_mode                 (quiet_mode),
		.cycle_active               (cycle_active)
	);

	sisa_host_model host (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.line      (line),
		.go        (go),
		.start_len (start_len),
		.stop_len  (stop_len),
		.h_out     (h_out),
		.h_oe_n    (h_oe_n),
		.done      (done),
		.seen      (seen)
	);

	// ==========================================================================
	// Compare, expectation and closing helpers
	task automatic chk1(input string what, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic chk16(input string what, input logic [16:1] e,
			input logic [16:1] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	// Slot 1 stays released, so the pull-up shows there
	function automatic logic [16:1] slots(input logic [15:1] q,
			input logic m, input logic en);
		slots = {q, 1'b1};
		slots[3] = en ? m : q[2];
	endfunction

	task automatic results();
		$display("Checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================================
	// Main sequence: first eight cycles stay Continuous and mix the slot 3
	// source; later ones tie both slot 3 sources together so a stale copy of
	// the unused one cannot fake a change, and mix Quiet and Continuous stops
	initial begin
		repeat (20) @(negedge mclk);
		chk1("oe_n in reset", 1'b1, dev_oe_n);
		chk1("mode in reset", 1'b0, quiet_mode);
		reset_n = 1'b1;
		for (k = 0; k < 20; k++) begin
			r = $random(seed);
			if (k != 12)
				irq_data = (k == 0) ? '0 : r[15:1];
			if (k < 8) begin
				smi_n = r[16];
				smi_en = r[17];
			end else
				smi_n = irq_data[2];
			start_len = 3'h3 + r[20:18] % 3'h5;
			// Stops after 8 and 11 force Quiet, so an own start is
			// seen at 9 and a Quiet cycle with no change at 12
			if (k < 8)
				stop_len = 3'h3;
			else if (k == 8 || k == 11)
				stop_len = 3'h2;
			else
				stop_len = 3'h2 + {2'h0, r[21]};
			exp_v = slots(irq_data, smi_n, smi_en);
			own = quiet_mode && (exp_v != last_v);
			repeat (10) @(negedge mclk);
			chk1("cycle_active", own, cycle_active);
			if (!own) begin
				go = 1'b1;
				@(negedge mclk);
				go = 1'b0;
			end
			for (i = 0; i < 120 && done !== 1'b1; i++)
				@(negedge mclk);
			chk1("done", 1'b1, done);
			chk16("slots", exp_v, seen);
			chk1("quiet_mode", stop_len == 3'h2, quiet_mode);
			last_v = exp_v;
			repeat (r[23:22]) @(negedge mclk);
		end
		results();
	end

	// Watchdog: twenty cycles need well under 3000 clocks
	initial begin
		#200000;
		bad_count++;
		results();
	end
endmodule

// ===== dv/sisa_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Host controller stand-in: runs one serial cycle when asked or when the
// agent opens a Start Frame, and records the level seen in every slot
module sisa_host_model (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        line,
	input  wire logic        go,
	input  wire logic [2:0]  start_len,
	input  wire logic [2:0]  stop_len,
	output logic             h_out,
	output logic             h_oe_n,
	output logic             done,
	output logic [16:1]      seen
);
	int n;
	int s;

	// Drive and sample on the rising edge only; released outside drives
	initial begin
		h_out = 1'b1;
		h_oe_n = 1'b1;
		done = 1'b0;
		seen = '1;
		forever begin
			@(posedge mclk);
			done <= 1'b0;
			if (reset_n && (go || line === 1'b0)) begin
				// An agent start already gave one low clock
				n = (line === 1'b0) ? start_len : start_len + 1;
				h_out <= 1'b0;
				h_oe_n <= 1'b0;
				repeat (n) @(posedge mclk);
				h_out <= 1'b1; // One high clock, then release
				@(posedge mclk);
				h_oe_n <= 1'b1;
				// Slot s is sampled at clock 3s-1 after the rising edge
				for (s = 1; s <= 16; s++) begin
					repeat ((s == 1) ? 2 : 3) @(posedge mclk);
					seen[s] <= line;
				end
				// Only the host ends the cycle, after slot 16 turnaround
				repeat (2) @(posedge mclk);
				h_out <= 1'b0;
				h_oe_n <= 1'b0;
				repeat (stop_len) @(posedge mclk);
				h_out <= 1'b1;
				@(posedge mclk);
				h_oe_n <= 1'b1;
				// Done is raised only after the full cycle; seen takes each level as its slot is sampled
				done <= 1'b1;
			end
		end
	end
endmodule

// ===== verilog/sisa_agent.sv
`timescale 1ns/1ps
module sisa_agent (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [15:1] irq_data,
	input  wire logic        system_mgmt_interrupt_n,
	input  wire logic        smi_slot_en,
	input  wire logic        serial_interrupt_line_in,
	output logic             serial_interrupt_line_out,
	output logic             serial_interrupt_line_oe_n,
	output logic             quiet_mode,
	output logic             cycle_active
);

	// ======================================================================
	// Declarations
	sisa_pkg::sisa_state_t   st_r;
	sisa_pkg::sisa_state_t   st_nxt;
	sisa_pkg::sisa_phase_t   ph_r;
	sisa_pkg::sisa_phase_t   ph_nxt;
	logic [4:0]              slot_r;
	logic [4:0]              slot_nxt;
	logic [5:0]              cnt_r;
	logic [5:0]              cnt_nxt;
	logic [2:0]              low_r;
	logic [2:0]              low_nxt;
	logic                    quiet_nxt;
	logic                    own_start;
	logic                    own_start_r;
	logic [16:0]             rep_r;
	logic [16:0]             rep_nxt;
	logic [16:0]             slot_lvl;
	logic [15:0]             lvl_sync;
	logic                    pend;
	logic                    line;
	logic                    in_sample;
	logic                    drv_sample;
	logic                    drv_recov;
	logic                    drove_low;
	logic                    out_nxt;
	logic                    oe_n_nxt;
	logic                    active_nxt;

	// ======================================================================
	// Request level capture
	// Requests come from other clock domains, so they are synchronised
	sisa_sync #(
		.W    (sisa_pkg::SYNC_W),
		.INIT ('1)
	) u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.d       ({irq_data, system_mgmt_interrupt_n}),
		.q       (lvl_sync)
	);

	// Slot map: slot 0 and slot 1 never report, slot s carries request s-1, except slot 3 carries the mgmt interrupt when smi_slot_en
	assign slot_lvl[16:4] = lvl_sync[15:3];
	assign slot_lvl[3]    = smi_slot_en ? lvl_sync[0] : lvl_sync[2];
	assign slot_lvl[2]    = lvl_sync[1];
	assign slot_lvl[1:0]  = 2'h3;

	// Outstanding change: level differs from what was last put on the wire
	assign pend = |(slot_lvl ^ rep_r);

	// The line is synchronous to mclk and is sampled on its rising edge
	assign line = serial_interrupt_line_in;

	// ======================================================================
	// Cycle tracking state machine
	always_comb begin
		st_nxt    = st_r;
		ph_nxt    = ph_r;
		slot_nxt  = slot_r;
		cnt_nxt   = cnt_r;
		low_nxt   = low_r;
		quiet_nxt = quiet_mode;
		own_start = 1'b0;
		case (st_r)
			sisa_pkg::ST_IDLE: begin
				if (!line) begin
					st_nxt = sisa_pkg::ST_START;
				end else if (quiet_mode && pend) begin
					// Only from idle, only in Quiet mode
					own_start = 1'b1;
					st_nxt    = sisa_pkg::ST_START;
				end
			end
			sisa_pkg::ST_START: begin
				// Rising edge of the Start pulse: clock 1 begins next
				// Any low width is followed until the host lets go
				if (line) begin
					st_nxt   = sisa_pkg::ST_FRAMES;
					ph_nxt   = sisa_pkg::PH_TURN;
					slot_nxt = sisa_pkg::SLOT_NONE;
					cnt_nxt  = sisa_pkg::CLK_FIRST;
				end
			end
			sisa_pkg::ST_FRAMES: begin
				cnt_nxt = cnt_r + sisa_pkg::CLK_STEP;
				case (ph_r)
					sisa_pkg::PH_SAMPLE: ph_nxt = sisa_pkg::PH_RECOV;
					sisa_pkg::PH_RECOV:  ph_nxt = sisa_pkg::PH_TURN;
					default: begin
						// Three clocks a frame, sample after turnaround
						if (slot_r == sisa_pkg::SLOT_LAST) begin
							st_nxt = sisa_pkg::ST_WAIT_STOP;
						end else begin
							ph_nxt   = sisa_pkg::PH_SAMPLE;
							slot_nxt = slot_r + sisa_pkg::SLOT_STEP;
						end
					end
				endcase
			end
			sisa_pkg::ST_WAIT_STOP: begin
				// Host may run extra frames; only the host ends the cycle
				if (!line) begin
					st_nxt  = sisa_pkg::ST_STOP_LOW;
					low_nxt = sisa_pkg::LOW_ONE;
				end
			end
			sisa_pkg::ST_STOP_LOW: begin
				if (!line) begin
					if (low_r != sisa_pkg::LOW_MAX) begin
						low_nxt = low_r + sisa_pkg::LOW_ONE;
					end
				end else if (low_r == sisa_pkg::STOP_QUIET) begin
					quiet_nxt = 1'b1;
					st_nxt    = sisa_pkg::ST_STOP_GAP;
				end else if (low_r == sisa_pkg::STOP_CONT) begin
					quiet_nxt = 1'b0;
					st_nxt    = sisa_pkg::ST_STOP_GAP;
				end else begin
					// Lows of one clock (late data frames) or of four or more clocks are not a Stop
					st_nxt = sisa_pkg::ST_WAIT_STOP;
				end
			end
			sisa_pkg::ST_STOP_GAP: begin
				// One clock of hold-off after the Stop rising edge
				st_nxt = sisa_pkg::ST_IDLE;
			end
			default: begin
				st_nxt = sisa_pkg::ST_IDLE;
			end
		endcase
	end

	// ======================================================================
	// Line drive decode, aligned to the clock being entered
	assign in_sample  = (st_nxt == sisa_pkg::ST_FRAMES) &&
	                    (ph_nxt == sisa_pkg::PH_SAMPLE);
	// Low only for a request whose last detected level is low
	assign drv_sample = in_sample && (slot_nxt != sisa_pkg::SLOT_UNUSED) &&
	                    !slot_lvl[slot_nxt];
	assign drove_low  = !serial_interrupt_line_oe_n &&
	                    !serial_interrupt_line_out;
	// High only right after our own sample-phase low
	assign drv_recov  = (st_nxt == sisa_pkg::ST_FRAMES) &&
	                    (ph_nxt == sisa_pkg::PH_RECOV) && drove_low;
	// Start is a single low clock, never followed by a high drive
	assign out_nxt    = !(own_start || drv_sample);
	// Turnaround and every other clock leave the line released
	assign oe_n_nxt   = !(own_start || drv_sample || drv_recov);
	assign active_nxt = (st_nxt != sisa_pkg::ST_IDLE) &&
	                    (st_nxt != sisa_pkg::ST_STOP_GAP);

	// Reported level is refreshed in every sample phase entered
	always_comb begin
		rep_nxt = rep_r;
		if (in_sample) begin
			rep_nxt[slot_nxt] = slot_lvl[slot_nxt];
		end
	end

	// ======================================================================
	// State registers
	// Reset assumes Continuous mode and releases the line
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st_r                       <= sisa_pkg::ST_IDLE;
			ph_r                       <= sisa_pkg::PH_TURN;
			slot_r                     <= sisa_pkg::SLOT_NONE;
			cnt_r                      <= '0;
			low_r                      <= '0;
			quiet_mode                 <= 1'b0;
			cycle_active               <= 1'b0;
			own_start_r                <= 1'b0;
			rep_r                      <= '1;
			serial_interrupt_line_out  <= 1'b1;
			serial_interrupt_line_oe_n <= 1'b1;
		end else begin
			st_r                       <= st_nxt;
			ph_r                       <= ph_nxt;
			slot_r                     <= slot_nxt;
			cnt_r                      <= cnt_nxt;
			low_r                      <= low_nxt;
			quiet_mode                 <= quiet_nxt;
			cycle_active               <= active_nxt;
			own_start_r                <= own_start;
			rep_r                      <= rep_nxt;
			serial_interrupt_line_out  <= out_nxt;
			serial_interrupt_line_oe_n <= oe_n_nxt;
		end
	end

	// ======================================================================
	// Assertions
	sequence seq_drive_low;
		!serial_interrupt_line_oe_n && !serial_interrupt_line_out;
	endsequence

	sequence seq_drive_high;
		!serial_interrupt_line_oe_n && serial_interrupt_line_out;
	endsequence

	sequence seq_released;
		serial_interrupt_line_oe_n;
	endsequence

	// Own start: one low clock, then released for the host's continuation
	AST_START_ONE_CLK: assert property (@(posedge mclk) disable iff (!reset_n)
		own_start_r |-> seq_drive_low ##1 seq_released [*3])
		else $error("Own start frame not a single low clock");

	AST_START_FROM_IDLE: assert property (@(posedge mclk)
		disable iff (!reset_n)
		own_start_r |-> $past(st_r) == sisa_pkg::ST_IDLE)
		else $error("Start frame begun while a cycle was active");

	AST_CONT_PASSIVE: assert property (@(posedge mclk) disable iff (!reset_n)
		own_start_r |-> $past(quiet_mode))
		else $error("Start frame begun in Continuous mode");

	AST_CHANGE_STARTS: assert property (@(posedge mclk)
		disable iff (!reset_n)
		(st_r == sisa_pkg::ST_IDLE && quiet_mode && pend && line)
		|=> own_start_r ##1 (st_r == sisa_pkg::ST_START))
		else $error("Pending change in Quiet idle did not start a frame");

	AST_MODE_ONLY_STOP: assert property (@(posedge mclk)
		disable iff (!reset_n)
		$changed(quiet_mode) |-> $past(st_r) == sisa_pkg::ST_STOP_LOW)
		else $error("Mode changed outside a Stop Frame");

	AST_STOP_WIDTH: assert property (@(posedge mclk) disable iff (!reset_n)
		(st_r == sisa_pkg::ST_STOP_LOW && line &&
		 (low_r == sisa_pkg::STOP_QUIET || low_r == sisa_pkg::STOP_CONT))
		|=> quiet_mode == ($past(low_r) == sisa_pkg::STOP_QUIET))
		else $error("Stop Frame width not adopted as mode");

	AST_RECOVERY: assert property (@(posedge mclk) disable iff (!reset_n)
		(st_r == sisa_pkg::ST_FRAMES && ph_r == sisa_pkg::PH_SAMPLE)
		##0 seq_drive_low |=> seq_drive_high ##1 seq_released)
		else $error("Sample low not followed by recovery high");

	AST_TURN_RELEASE: assert property (@(posedge mclk) disable iff (!reset_n)
		(st_r == sisa_pkg::ST_FRAMES && ph_r == sisa_pkg::PH_TURN)
		|-> seq_released)
		else $error("Line driven in a turnaround phase");

	AST_SLOT_CLOCK: assert property (@(posedge mclk) disable iff (!reset_n)
		(st_r == sisa_pkg::ST_FRAMES) ##0 seq_drive_low
		|-> (cnt_r % sisa_pkg::FRAME_CLKS == sisa_pkg::SAMPLE_REM) &&
		    cnt_r >= sisa_pkg::CLK_FIRST_REQ &&
		    cnt_r <= sisa_pkg::CLK_LAST_REQ)
		else $error("Sample drive outside a request slot clock");

	AST_SAMPLE_LEVEL: assert property (@(posedge mclk)
		disable iff (!reset_n)
		(st_r == sisa_pkg::ST_FRAMES && ph_r == sisa_pkg::PH_SAMPLE)
		|-> serial_interrupt_line_oe_n == rep_r[slot_r])
		else $error("Sample drive disagrees with reported level");

	AST_RESET_RELEASE: assert property (@(posedge mclk)
		disable iff (!reset_n)
		$rose(reset_n) |-> seq_released ##1 seq_released)
		else $error("Line driven across reset release");

endmodule

// ===== verilog/sisa_pkg.sv
// ==========================================================================
// Shared constants for the serial interrupt slave agent
package sisa_pkg;

	// Width of the synchronised level bundle: {irq 15..1, mgmt interrupt}
	localparam int         SYNC_W        = 16;
	// Slot numbering, slot 0 is the lead-in clock before slot 1
	localparam logic [4:0] SLOT_NONE     = 5'h00;
	localparam logic [4:0] SLOT_UNUSED   = 5'h01;
	localparam logic [4:0] SLOT_LAST     = 5'h10;
	// Stop Frame low widths and the saturation point of the width counter
	localparam logic [2:0] LOW_ONE       = 3'h1;
	localparam logic [2:0] STOP_QUIET    = 3'h2;
	localparam logic [2:0] STOP_CONT     = 3'h3;
	localparam logic [2:0] LOW_MAX       = 3'h7;
	// Clock positions counted from the Start pulse rising edge
	localparam logic [5:0] CLK_FIRST     = 6'h01;
	localparam logic [5:0] CLK_STEP      = 6'h01;
	localparam logic [5:0] FRAME_CLKS    = 6'h03;
	localparam logic [5:0] SAMPLE_REM    = 6'h02;
	localparam logic [5:0] CLK_FIRST_REQ = 6'h05;
	localparam logic [5:0] CLK_LAST_REQ  = 6'h2f;
	localparam logic [4:0] SLOT_STEP     = 5'h01;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_START     = 3'b001,
		ST_FRAMES    = 3'b010,
		ST_WAIT_STOP = 3'b011,
		ST_STOP_LOW  = 3'b100,
		ST_STOP_GAP  = 3'b101
	} sisa_state_t;

	typedef enum logic [1:0] {
		PH_SAMPLE = 2'b00,
		PH_RECOV  = 2'b01,
		PH_TURN   = 2'b10
	} sisa_phase_t;

endpackage

// ===== verilog/sisa_sync.sv
`timescale 1ns/1ps
// ==========================================================================
// Three-stage level synchroniser; a bit moves only once stages two and
// three agree, so a single metastable sample never reaches the output
module sisa_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] agree;
	logic [W-1:0] q_nxt;

	// Per-bit agreement between the two settled stages
	assign agree = ~(s2_r ^ s3_r);
	assign q_nxt = (agree & s3_r) | (~agree & q);

	// Stage one feeds only stage two
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			q    <= INIT;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q    <= q_nxt;
		end
	end

endmodule
